// File: core/tprc_params.svh
// Constants for the tape panel rewind and load-point control block.
// Assumes inclusion by bare name from files in core/.
`ifndef TPRC_PARAMS_SVH
`define TPRC_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define TPRC_CLK_MHZ         250
`define TPRC_BLINK_TIME_MS   100
`define TPRC_BLINK_CYCLES    (`TPRC_BLINK_TIME_MS * 1000 * `TPRC_CLK_MHZ)

// ----------------------------------------------------------------------
// Tape speeds in inches per second
// ----------------------------------------------------------------------
`define TPRC_SPEED_W         8
`define TPRC_REWIND_IPS      8'hF0
`define TPRC_NORMAL_IPS      8'h78
`define TPRC_STOP_IPS        8'h00

// ----------------------------------------------------------------------
// Input sampler width: switches, sensors and control unit lines
// ----------------------------------------------------------------------
`define TPRC_IN_W            14

// ----------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------
`define TPRC_ADDR_W          4
`define TPRC_OFS_CTRL        4'h0
`define TPRC_OFS_STATUS      4'h4
`define TPRC_OFS_BLINK       4'h8

// Control register fields and reset value.
`define TPRC_CTRL_PANEL_EN   0
`define TPRC_CTRL_CU_EN      1
`define TPRC_CTRL_RESET      2'h3

// Status register fields.
`define TPRC_STAT_LAMP_LSB   0
`define TPRC_STAT_LAMP_MSB   6
`define TPRC_STAT_STATE_LSB  8
`define TPRC_STAT_STATE_MSB  14
`define TPRC_STAT_PASSED     16
`define TPRC_STAT_BY_PANEL   17

`endif

// File: core/tprc_pkg.sv
// Types shared by the tape panel rewind and load-point control block.
// Assumes nothing beyond a SystemVerilog compiler.
package tprc_pkg;

    // ------------------------------------------------------------------
    // Input groups
    // ------------------------------------------------------------------
    typedef struct packed {
        logic on_sw;
        logic off_sw;
        logic fwd_sw;
        logic bwd_sw;
        logic rewind_sw;
        logic load_point_sw;
        logic remote_sw;
    } tprc_switch_type;

    typedef struct packed {
        logic marker;
        logic unload_point;
        logic vac_fault;
    } tprc_sense_type;

    typedef struct packed {
        logic rewind_il;
        logic rewind_lp;
        logic fwd;
        logic bwd;
    } tprc_cu_type;

    // ------------------------------------------------------------------
    // Output groups
    // ------------------------------------------------------------------
    typedef struct packed {
        logic on;
        logic local_mode;
        logic remote_mode;
        logic forward;
        logic backward;
        logic rewind;
        logic load_point;
    } tprc_lamp_type;

    typedef struct packed {
        logic       run;
        logic       reverse;
        logic [7:0] speed_ips;
    } tprc_motion_type;

    // ------------------------------------------------------------------
    // Motion sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_LP_FWD  = 7'h02,
        ST_RW_IL   = 7'h04,
        ST_RW_LP   = 7'h08,
        ST_MAN_FWD = 7'h10,
        ST_MAN_BWD = 7'h20,
        ST_CU_MOVE = 7'h40
    } tprc_state_type;

endpackage

// File: core/tprc_sampler.sv
// Input sampler: registers every panel, sensor and control unit line and
// flags the first sampled cycle of each rising level.
// Assumes the inputs are already synchronous to i_clk.
`timescale 1ns/100ps
`include "tprc_params.svh"

module tprc_sampler
(
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Raw lines
    input  wire logic [`TPRC_IN_W-1:0]  i_raw,
    // Sampled level and first-cycle pulse
    output logic      [`TPRC_IN_W-1:0]  o_level,
    output logic      [`TPRC_IN_W-1:0]  o_rise
);

    logic [`TPRC_IN_W-1:0] level_ff;
    logic [`TPRC_IN_W-1:0] rise_ff;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            level_ff <= '0;
            rise_ff  <= '0;
        end
        else
        begin
            level_ff <= i_raw;
            rise_ff  <= i_raw & ~level_ff;
        end
    end

    assign o_level = level_ff;
    assign o_rise  = rise_ff;

endmodule

// File: core/tprc_ctrl.sv
// Operator panel control for a reel-to-reel tape unit: rewind and
// load-point switch handling, indicators and motion commands, with an
// Avalon-MM slave for control and status.
// Assumes synchronous inputs and an Avalon master that holds its request
// until it samples waitrequest low.
`timescale 1ns/100ps
`include "tprc_params.svh"

module tprc_ctrl
#(
    parameter logic [31:0] P_BLINK_CYCLES = 32'(`TPRC_BLINK_CYCLES)
)
(
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    // Panel switches, sensors and control unit requests
    input  wire tprc_pkg::tprc_switch_type     i_switch,
    input  wire tprc_pkg::tprc_sense_type      i_sense,
    input  wire tprc_pkg::tprc_cu_type         i_cu,
    // Indicators and motion command
    output tprc_pkg::tprc_lamp_type            o_lamp,
    output tprc_pkg::tprc_motion_type          o_motion,
    // Avalon-MM slave
    input  wire logic [`TPRC_ADDR_W-1:0]       i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [31:0]                   i_avs_writedata,
    input  wire logic [3:0]                    i_avs_byteenable,
    output logic      [31:0]                   o_avs_readdata,
    output logic                               o_avs_waitrequest
);

    // ------------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------------
    logic [`TPRC_IN_W-1:0]     in_level;
    logic [`TPRC_IN_W-1:0]     in_rise;
    tprc_pkg::tprc_switch_type sw_lvl;
    tprc_pkg::tprc_switch_type sw_rise;
    tprc_pkg::tprc_sense_type  sen;
    tprc_pkg::tprc_cu_type     cu;
    tprc_pkg::tprc_cu_type     cu_rise;

    tprc_sampler u_sampler
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_raw   ({i_switch, i_sense, i_cu}),
        .o_level (in_level),
        .o_rise  (in_rise)
    );

    assign sw_lvl  = in_level[13:7];
    assign sw_rise = in_rise[13:7];
    assign sen     = in_level[6:4];
    assign cu      = in_level[3:0];
    assign cu_rise = in_rise[3:0];

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    tprc_pkg::tprc_state_type  state_ff;
    tprc_pkg::tprc_state_type  nxt_state;
    tprc_pkg::tprc_lamp_type   lamp_ff;
    tprc_pkg::tprc_lamp_type   nxt_lamp;
    tprc_pkg::tprc_motion_type motion_ff;
    tprc_pkg::tprc_motion_type nxt_motion;
    logic                      passed_ff;
    logic                      by_panel_ff;
    logic [31:0]               blink_cnt_ff;
    logic [1:0]                ctrl_ff;
    logic [31:0]               blink_len_ff;
    logic                      wait_ff;
    logic [31:0]               rdata_ff;

    logic panel_en;
    logic cu_en;
    logic fault;
    logic abort;
    logic local_on;
    logic rewind_go;
    logic lp_go;
    logic convert;
    logic manual;
    logic blink_over;
    logic bus_req;
    logic bus_commit;

    assign panel_en = ctrl_ff[`TPRC_CTRL_PANEL_EN];
    assign cu_en    = ctrl_ff[`TPRC_CTRL_CU_EN];

    // power lost on off or column fault
    assign fault    = (panel_en & sw_rise.off_sw) | sen.vac_fault;
    assign abort    = fault | ~lamp_ff.on;
    assign local_on = lamp_ff.on & lamp_ff.local_mode;

    assign rewind_go = panel_en & sw_rise.rewind_sw & local_on & ~sen.unload_point & ~fault;

    assign lp_go = panel_en & sw_rise.load_point_sw & local_on & ~fault;

    // panel rewind converted by either switch
    // any rewind converted before the marker
    assign convert = (state_ff == tprc_pkg::ST_RW_IL) & ~passed_ff & panel_en &
                     (sw_rise.load_point_sw | (sw_rise.remote_sw & by_panel_ff));

    assign manual = (state_ff == tprc_pkg::ST_MAN_FWD) | (state_ff == tprc_pkg::ST_MAN_BWD);

    // ------------------------------------------------------------------
    // Motion sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            tprc_pkg::ST_IDLE:
            begin
                if (abort)
                    nxt_state = tprc_pkg::ST_IDLE;
                else if (rewind_go)
                    nxt_state = tprc_pkg::ST_RW_IL;
                // no motion already at the marker
                else if (lp_go)
                    nxt_state = sen.marker ? tprc_pkg::ST_IDLE : tprc_pkg::ST_LP_FWD;
                else if (cu_en & lamp_ff.remote_mode & cu_rise.rewind_il & ~sen.unload_point)
                    nxt_state = tprc_pkg::ST_RW_IL;
                else if (cu_en & lamp_ff.remote_mode & cu_rise.rewind_lp & ~sen.marker)
                    nxt_state = tprc_pkg::ST_RW_LP;
                else if (cu_en & lamp_ff.remote_mode & (cu.fwd ^ cu.bwd))
                    nxt_state = tprc_pkg::ST_CU_MOVE;
                else if (panel_en & local_on & sw_rise.fwd_sw)
                    nxt_state = tprc_pkg::ST_MAN_FWD;
                else if (panel_en & local_on & sw_rise.bwd_sw & ~sen.unload_point)
                    nxt_state = tprc_pkg::ST_MAN_BWD;
            end
            tprc_pkg::ST_RW_IL:
            begin
                if (abort | sen.unload_point)
                    nxt_state = tprc_pkg::ST_IDLE;
                else if (convert)
                    nxt_state = tprc_pkg::ST_RW_LP;
            end
            tprc_pkg::ST_RW_LP:
            begin
                if (abort | sen.marker)
                    nxt_state = tprc_pkg::ST_IDLE;
            end
            tprc_pkg::ST_LP_FWD:
            begin
                // halt on off or column fault
                if (abort | sen.marker)
                    nxt_state = tprc_pkg::ST_IDLE;
            end
            tprc_pkg::ST_MAN_FWD:
            begin
                if (abort | ~sw_lvl.fwd_sw)
                    nxt_state = tprc_pkg::ST_IDLE;
            end
            tprc_pkg::ST_MAN_BWD:
            begin
                if (abort | ~sw_lvl.bwd_sw | sen.unload_point)
                    nxt_state = tprc_pkg::ST_IDLE;
            end
            tprc_pkg::ST_CU_MOVE:
            begin
                if (abort | ~(cu.fwd ^ cu.bwd))
                    nxt_state = tprc_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_state = tprc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            state_ff <= tprc_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Marker-passed and origin flags for the rewind in progress.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            passed_ff   <= 1'b0;
            by_panel_ff <= 1'b0;
        end
        else if (state_ff == tprc_pkg::ST_IDLE)
        begin
            passed_ff   <= 1'b0;
            by_panel_ff <= rewind_go;
        end
        else if (sen.marker)
        begin
            passed_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Motion command
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_motion.run       = 1'b1;
        nxt_motion.reverse   = 1'b0;
        nxt_motion.speed_ips = `TPRC_NORMAL_IPS;
        case (nxt_state)
            tprc_pkg::ST_RW_IL,
            tprc_pkg::ST_RW_LP:
            begin
                nxt_motion.reverse   = 1'b1;
                nxt_motion.speed_ips = `TPRC_REWIND_IPS;
            end
            tprc_pkg::ST_LP_FWD,
            tprc_pkg::ST_MAN_FWD:
            begin
                nxt_motion.reverse = 1'b0;
            end
            tprc_pkg::ST_MAN_BWD:
            begin
                nxt_motion.reverse = 1'b1;
            end
            tprc_pkg::ST_CU_MOVE:
            begin
                nxt_motion.reverse = cu.bwd;
            end
            default:
            begin
                nxt_motion.run       = 1'b0;
                nxt_motion.speed_ips = `TPRC_STOP_IPS;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            motion_ff <= '0;
        else
            motion_ff <= nxt_motion;
    end

    // ------------------------------------------------------------------
    // Load-point blink timer
    // ------------------------------------------------------------------
    // The timer only runs while a manual switch holds the tape moving over
    // the marker, so a stop on the marker by any other motion stays lit.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            blink_cnt_ff <= 32'h0000_0000;
        else if (~(manual & sen.marker))
            blink_cnt_ff <= 32'h0000_0000;
        else if (~blink_over)
            blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
    end

    assign blink_over = manual & (blink_cnt_ff >= blink_len_ff);

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_lamp = lamp_ff;
        if (fault)
            nxt_lamp.on = 1'b0;
        else if (panel_en & sw_rise.on_sw)
            nxt_lamp.on = 1'b1;

        if (panel_en & sw_rise.off_sw)
        begin
            nxt_lamp.local_mode  = 1'b1;
            nxt_lamp.remote_mode = 1'b0;
        end
        else if (convert | lp_go | (panel_en & sw_rise.remote_sw & local_on))
        begin
            nxt_lamp.local_mode  = 1'b0;
            nxt_lamp.remote_mode = 1'b1;
        end

        if (state_ff == tprc_pkg::ST_IDLE && nxt_state != tprc_pkg::ST_IDLE)
        begin
            nxt_lamp.forward  = ~nxt_motion.reverse;
            nxt_lamp.backward = nxt_motion.reverse;
        end
        else if (lp_go | (panel_en & local_on & sw_rise.fwd_sw))
        begin
            nxt_lamp.forward  = 1'b1;
            nxt_lamp.backward = 1'b0;
        end
        else if (panel_en & local_on & sw_rise.bwd_sw)
        begin
            nxt_lamp.forward  = 1'b0;
            nxt_lamp.backward = 1'b1;
        end

        // rewind lamp on any rewind start
        // rewind lamp off at end or power loss
        if (nxt_state == tprc_pkg::ST_RW_IL || nxt_state == tprc_pkg::ST_RW_LP)
            nxt_lamp.rewind = 1'b1;
        else
            nxt_lamp.rewind = 1'b0;
        if (~nxt_lamp.on)
            nxt_lamp.rewind = 1'b0;

        // dark on off or column fault
        nxt_lamp.load_point = nxt_lamp.on & ~fault & sen.marker & ~blink_over;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lamp_ff            <= '0;
            lamp_ff.local_mode <= 1'b1;
        end
        else
        begin
            lamp_ff <= nxt_lamp;
        end
    end

    assign o_lamp   = lamp_ff;
    assign o_motion = motion_ff;

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // Fixed latency of one wait cycle: waitrequest drops for exactly one
    // cycle per request, and the write lands on the edge that ends that cycle.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = new_val[i*8 +: 8];
        end
        return res;
    endfunction

    assign bus_req    = i_avs_read | i_avs_write;
    assign bus_commit = bus_req & ~wait_ff;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            wait_ff <= 1'b1;
        else
            wait_ff <= ~(bus_req & wait_ff);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_ff      <= `TPRC_CTRL_RESET;
            blink_len_ff <= P_BLINK_CYCLES;
        end
        else if (bus_commit & i_avs_write)
        begin
            if (i_avs_address == `TPRC_OFS_CTRL)
                ctrl_ff <= 2'(merge_bytes({30'h0, ctrl_ff}, i_avs_writedata,
                                          i_avs_byteenable));
            else if (i_avs_address == `TPRC_OFS_BLINK)
                blink_len_ff <= merge_bytes(blink_len_ff, i_avs_writedata,
                                            i_avs_byteenable);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if (bus_req & wait_ff & i_avs_read)
        begin
            rdata_ff <= 32'h0000_0000;
            case (i_avs_address)
                `TPRC_OFS_CTRL:
                    rdata_ff[1:0] <= ctrl_ff;
                `TPRC_OFS_STATUS:
                begin
                    rdata_ff[`TPRC_STAT_LAMP_MSB:`TPRC_STAT_LAMP_LSB]   <= lamp_ff;
                    rdata_ff[`TPRC_STAT_STATE_MSB:`TPRC_STAT_STATE_LSB] <= state_ff;
                    rdata_ff[`TPRC_STAT_PASSED]                         <= passed_ff;
                    rdata_ff[`TPRC_STAT_BY_PANEL]                       <= by_panel_ff;
                end
                `TPRC_OFS_BLINK:
                    rdata_ff <= blink_len_ff;
                default:
                    rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;

endmodule

// File: verif/tprc_ctrl_asserts.sv
// Checker for the tape panel control block: lamps and motion versus inputs.
// Assumes binding onto tprc_ctrl from the bench top.
`timescale 1ns/100ps
module tprc_ctrl_asserts
(
    // Watched ports
    input wire logic                      i_clk,
    input wire logic                      i_rst,
    input wire tprc_pkg::tprc_switch_type i_switch,
    input wire tprc_pkg::tprc_sense_type  i_sense,
    input wire tprc_pkg::tprc_cu_type     i_cu,
    input wire tprc_pkg::tprc_lamp_type   o_lamp,
    input wire tprc_pkg::tprc_motion_type o_motion
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // A panel press only starts motion from an idle, powered, local unit.
    wire logic ok = o_lamp.on && o_lamp.local_mode && !o_motion.run;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_pwr; !o_lamp.on |-> !o_lamp.load_point; endproperty
    a_pwr: assert property (p_pwr)
        else $error("load point lamp lit without power");
    property p_rw; $rose(i_switch.rewind_sw) && ok && !i_sense.unload_point |-> ##2
        o_motion == 10'h3F0 && o_lamp.rewind && o_lamp.backward && !o_lamp.forward;
    endproperty
    a_rw: assert property (p_rw)
        else $error("rewind press not answered");
    property p_ign; $rose(i_switch.rewind_sw) && !o_lamp.on |-> ##2 !o_motion.run; endproperty
    a_ign: assert property (p_ign)
        else $error("rewind press acted while off");
    property p_unl; o_motion.run && o_lamp.rewind && o_lamp.local_mode
        && i_sense.unload_point |-> ##2 !o_motion.run && !o_lamp.rewind; endproperty
    a_unl: assert property (p_unl)
        else $error("rewind ran past unload point");
    property p_cnv; $rose(i_switch.load_point_sw) && o_motion.run && o_lamp.rewind
        && o_lamp.local_mode |-> ##2 o_lamp.remote_mode && !o_lamp.local_mode
        && o_motion.run; endproperty
    a_cnv: assert property (p_cnv)
        else $error("rewind not converted");
    property p_lp; $rose(i_switch.load_point_sw) && ok && !i_sense.marker |-> ##2
        o_motion == 10'h278 && o_lamp.remote_mode && o_lamp.forward && !o_lamp.local_mode;
    endproperty
    a_lp: assert property (p_lp)
        else $error("load point press not answered");
    property p_at; $rose(i_switch.load_point_sw) && ok && i_sense.marker |-> ##2
        !o_motion.run; endproperty
    a_at: assert property (p_at)
        else $error("motion started at load point");
    property p_stp; o_motion.run && !o_motion.reverse && !i_cu.fwd && o_lamp.remote_mode
        && i_sense.marker |-> ##2 !o_motion.run; endproperty
    a_stp: assert property (p_stp)
        else $error("forward motion ran past marker");
    property p_off; $rose(i_switch.off_sw) |-> ##2 !o_lamp.on && !o_lamp.load_point
        && !o_motion.run && o_lamp.local_mode; endproperty
    a_off: assert property (p_off)
        else $error("off press not answered");
    property p_vac; i_sense.vac_fault |-> ##2 !o_lamp.on && !o_lamp.load_point; endproperty
    a_vac: assert property (p_vac)
        else $error("column fault left lamps lit");
    property p_cu; $rose(i_cu.rewind_lp) && o_lamp.remote_mode && !o_motion.run |-> ##2
        o_lamp.rewind && o_motion.run && o_motion.reverse; endproperty
    a_cu: assert property (p_cu)
        else $error("program rewind not started");
endmodule

// File: verif/tprc_tape_model.sv
// Tape transport model: position, load-point marker and unload point.
// Assumes one position step per clock while motion is commanded.
`timescale 1ns/100ps
module tprc_tape_model
(
    // Preset and fault from the bench
    input  wire logic                      i_clk,
    input  wire logic                      i_set,
    input  wire logic [7:0]                i_pos,
    input  wire logic                      i_fault,
    // Motion in, sensing out
    input  wire tprc_pkg::tprc_motion_type i_motion,
    output tprc_pkg::tprc_sense_type       o_sense
);
    logic [7:0] pos_ff;
    always_ff @(posedge i_clk)
    begin
        if (i_set)
            pos_ff <= i_pos;
        else if (i_motion.run && i_motion.reverse && pos_ff != 8'h00)
            pos_ff <= pos_ff - 8'h01;
        else if (i_motion.run && !i_motion.reverse && pos_ff != 8'hFF)
            pos_ff <= pos_ff + 8'h01;
    end
    // The marker spans several steps so that it is still seen after stopping.
    assign o_sense.marker       = pos_ff >= 8'h10 && pos_ff <= 8'h17;
    assign o_sense.unload_point = pos_ff == 8'h00;
    assign o_sense.vac_fault    = i_fault;
endmodule

// File: verif/tprc_ctrl_tb_top.sv
// Testbench for the tape panel control block.
// Assumes the tape model on the sensing side and an Avalon master here.
`timescale 1ns/100ps
module tprc_ctrl_tb_top;
    logic                      i_clk, i_rst, set, fault, rd, wr, wt;
    logic [7:0]                pos;
    logic [3:0]                adr;
    logic [31:0]               wd, rdq, rdat;
    tprc_pkg::tprc_switch_type sw;
    tprc_pkg::tprc_sense_type  sen;
    tprc_pkg::tprc_cu_type     cu;
    tprc_pkg::tprc_lamp_type   lamp;
    tprc_pkg::tprc_motion_type mot;
    int                        errors, checks;

    tprc_ctrl #(.P_BLINK_CYCLES(32'h14)) tprc_ctrl_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_switch(sw), .i_sense(sen), .i_cu(cu), .o_lamp(lamp), .o_motion(mot),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdq), .o_avs_waitrequest(wt));
    tprc_tape_model tprc_tape_model_i (.i_clk(i_clk), .i_set(set), .i_pos(pos),
        .i_fault(fault), .i_motion(mot), .o_sense(sen));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge i_clk); while (wt !== 1'b0);
        rdat = rdq;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic press(input int b);
        @(posedge i_clk);
        sw[b] <= 1'b1;
        tk(3);
        sw[b] <= 1'b0;
        tk(3);
    endtask
    task automatic setpos(input logic [7:0] p);
        @(posedge i_clk);
        pos <= p;
        set <= 1'b1;
        @(posedge i_clk);
        set <= 1'b0;
    endtask
    task automatic wstop;
        repeat (400) if (mot.run === 1'b1) tk(1);
        tk(3);
    endtask
    task automatic conclude;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        bus(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h3);
        bus(1'b0, 4'h8, 32'h0);
        chk(rdat, 32'h14);
        bus(1'b0, 4'hC, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b1, 4'h4, 32'hFFFFFFFF);
        bus(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h120);
        $display("test regs done");
    endtask
    task automatic t_rewind;
        press(2);
        chk(mot, 10'h0);
        press(6);
        chk(lamp, 7'h60);
        press(2);
        chk(mot, 10'h3F0);
        chk(lamp[3:1], 3'h3);
        wstop;
        chk({sen.unload_point, lamp.rewind, mot.run}, 3'h4);
        setpos(8'h40);
        press(2);
        press(1);
        chk({lamp[5:4], mot.speed_ips}, 10'h1F0);
        wstop;
        chk({sen.marker, lamp.load_point}, 2'h3);
        $display("test rewind done");
    endtask
    task automatic t_load;
        setpos(8'h40);
        @(posedge i_clk);
        cu.rewind_lp <= 1'b1;
        tk(3);
        chk(lamp.rewind, 1'b1);
        chk(lamp.load_point, 1'b0);
        cu.rewind_lp <= 1'b0;
        wstop;
        chk(lamp[1:0], 2'h1);
        press(5);
        chk(lamp, 7'h24);
        press(6);
        setpos(8'h05);
        press(1);
        chk({lamp[5:3], mot}, 13'h0E78);
        wstop;
        chk(lamp.load_point, 1'b1);
        press(5);
        press(6);
        press(1);
        chk(mot.run, 1'b0);
        $display("test load point done");
    endtask
    task automatic t_misc;
        @(posedge i_clk);
        fault <= 1'b1;
        tk(3);
        chk({lamp.on, lamp.load_point}, 2'h0);
        fault <= 1'b0;
        press(5);
        press(6);
        bus(1'b1, 4'h0, 32'h2);
        press(4);
        chk(mot.run, 1'b0);
        bus(1'b1, 4'h0, 32'h3);
        bus(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h3);
        bus(1'b1, 4'h8, 32'h2);
        press(4);
        chk(lamp.load_point, 1'b0);
        $display("test misc done");
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial
    begin
        tk(20000);
        errors++;
        conclude;
    end
    initial
    begin
        {i_rst, set, pos, adr, wd} = {2'h3, 8'h30, 36'h0};
        {sw, cu, fault, rd, wr, errors, checks} = '0;
        tk(12);
        i_rst <= 1'b0;
        set <= 1'b0;
        tk(3);
        t_regs;
        t_rewind;
        t_load;
        t_misc;
        conclude;
    end
endmodule

bind tprc_ctrl tprc_ctrl_asserts tprc_ctrl_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_switch(i_switch), .i_sense(i_sense), .i_cu(i_cu), .o_lamp(o_lamp),
    .o_motion(o_motion));
